/* File: hw/sbr_baud_gen.sv */
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Baud rate generator with APB register access
// ---------------------------------------------------------------
module sbr_baud_gen
#(
  parameter int TICK_CNT_W = 32 // Width of the bit tick counter
)
(
  // Generator clock and chip reset
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [sbr_pkg::APB_ADDR_W-1:0]  paddr,
  input  wire logic [sbr_pkg::APB_DATA_W-1:0]  pwdata,
  input  wire logic [sbr_pkg::APB_STRB_W-1:0]  pstrb,
  output logic      [sbr_pkg::APB_DATA_W-1:0]  prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Shared bit rate enable for receiver and transmitter
  output logic                                 baudTick
);
  import sbr_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  typedef struct packed {
    logic                  pready;    // Access phase answer
    logic                  pslverr;   // Error answer
    logic [APB_DATA_W-1:0] prdata;    // Read data, latched in setup
    logic [PRE_SEL_W-1:0]  prescale;  // Prescale code
    logic [RATE_SEL_W-1:0] rate;      // Rate exponent code
    logic                  restart;   // Divider restart pulse
    logic                  baudTick;  // Bit rate enable
    logic [TICK_CNT_W-1:0] tickCount; // Bit ticks since reset
  } sbr_top_state_t;

  // Reset image, taken from the package reset values
  localparam sbr_top_state_t STATE_RST = '{
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    '0,
    prescale:  BAUD_SEL_RST[PRE_SEL_LSB +: PRE_SEL_W],
    rate:      BAUD_SEL_RST[RATE_SEL_LSB +: RATE_SEL_W],
    restart:   1'b0,
    baudTick:  1'b0,
    tickCount: TICK_CNT_W'(TICK_CNT_RST)
  };

  sbr_top_state_t state;       // Current state
  sbr_top_state_t next_state;  // Next state
  logic           setupPhase;  // APB setup cycle
  logic           accessDone;  // APB access completes at this edge
  logic           cfgCommit;   // Write to the rate selection byte
  logic           addrMapped;  // Address hits a register
  logic [7:0]     baudByte;    // Rate selection as read back

  sbr_div_if div (); // Link to the divider stages

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------

  // Phases follow the APB handshake; pready is our own flop
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && state.pready;
  assign addrMapped = (paddr == BAUD_SEL_OFS) || (paddr == TICK_CNT_OFS);
  // Only byte lane 0 carries the selection fields
  assign cfgCommit  = accessDone && pwrite && (paddr == BAUD_SEL_OFS)
                      && pstrb[0];

  // Read view of the selection register, unused bits zero
  always_comb
  begin
    baudByte                                = 8'h00;
    baudByte[PRE_SEL_LSB +: PRE_SEL_W]      = state.prescale;
    baudByte[RATE_SEL_LSB +: RATE_SEL_W]    = state.rate;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Bus slave, selection register and tick output in one place
  always_comb
  begin
    next_state         = state;
    next_state.restart = 1'b0;
    // A tick caught in flight during a restart belongs to the old rate
    next_state.baudTick = div.baudTick && !state.restart;
    if (state.baudTick)
    begin
      // Counter wraps; software sees progress of the shared rate
      next_state.tickCount = state.tickCount + 1'b1;
    end
    if (setupPhase)
    begin
      // Answer in the first access cycle, zero wait states
      next_state.pready  = 1'b1;
      next_state.pslverr = !addrMapped || (pwrite && paddr == TICK_CNT_OFS);
      if (pwrite || !addrMapped)
      begin
        next_state.prdata = '0;
      end
      else if (paddr == BAUD_SEL_OFS)
      begin
        next_state.prdata = {{(APB_DATA_W-8){1'b0}}, baudByte};
      end
      else
      begin
        next_state.prdata = APB_DATA_W'(state.tickCount);
      end
    end
    else if (accessDone)
    begin
      next_state.pready  = 1'b0;
      next_state.pslverr = 1'b0;
      next_state.prdata  = '0;
      if (cfgCommit)
      begin
        // Both fields load together and the chain restarts, even when
        // the value is unchanged, so software gets a clean bit edge
        next_state.prescale = pwdata[PRE_SEL_LSB +: PRE_SEL_W];
        next_state.rate     = pwdata[RATE_SEL_LSB +: RATE_SEL_W];
        next_state.restart  = 1'b1;
      end
    end
  end

  // Register the state; reset clears both codes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= STATE_RST;
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------
  // Divider chain
  // ---------------------------------------------------------------

  // A single code pair drives one chain; no per-direction copy exists
  assign div.restart     = state.restart;
  assign div.prescaleSel = state.prescale;
  assign div.rateSel     = state.rate;

  // Prescale stage on the generator clock
  sbr_prescaler u_pre (
    .mclk  (mclk),
    .rst_n (rst_n),
    .div   (div)
  );

  // Fixed and power-of-two stage
  sbr_rate_div u_rate (
    .mclk  (mclk),
    .rst_n (rst_n),
    .div   (div)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign prdata   = state.prdata;
  assign pready   = state.pready;
  assign pslverr  = state.pslverr;
  assign baudTick = state.baudTick;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  logic                cfgWritten; // Selection written since reset
  logic                fresh;      // No full bit since restart
  logic [PERIOD_W-1:0] gapCnt;     // Cycles since the last tick

  // Helper state for the checks only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgWritten <= 1'b0;
      fresh      <= 1'b1;
      gapCnt     <= '0;
    end
    else
    begin
      if (cfgCommit)
        cfgWritten <= 1'b1;
      if (state.restart)
        fresh <= 1'b1;
      else if (state.baudTick)
        fresh <= 1'b0;
      if (state.baudTick)
        gapCnt <= '0;
      else
        gapCnt <= gapCnt + 1'b1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rst_n);

  // Completed write to the selection byte
  sequence s_cfg_write;
    psel && penable && pready && pwrite && (paddr == BAUD_SEL_OFS) && pstrb[0];
  endsequence

  // Setup of a read from the selection register
  sequence s_cfg_read;
    psel && !penable && !pwrite && (paddr == BAUD_SEL_OFS);
  endsequence

  // Restart runs one cycle, then drops
  sequence s_restart_pulse;
    div.restart ##1 !div.restart;
  endsequence

  a_prescale_load: assert property (
    s_cfg_write |=> (div.prescaleSel == $past(pwdata[5:4]))
                    && (sbr_prescale_factor(div.prescaleSel)
                        == sbr_prescale_factor($past(pwdata[5:4]))))
    else $error("prescale code not loaded from the write");

  a_cfg_readback: assert property (
    s_cfg_read |=> pready && (prdata[5:4] == div.prescaleSel)
                   && (prdata[2:0] == div.rateSel) && (prdata[31:6] == '0))
    else $error("selection register read back wrong");

  a_prescale_reset: assert property (
    !cfgWritten |-> (div.prescaleSel == 2'b00))
    else $error("prescale code not cleared by reset");

  a_rate_reset: assert property (
    !cfgWritten |-> (div.rateSel == 3'b000))
    else $error("rate code not cleared by reset");

  // A tick already in flight when the restart lands still carries the
  // old spacing, so the restart cycle itself is not judged
  a_bit_period: assert property (
    (baudTick && !fresh && !div.restart) |->
      (gapCnt == PERIOD_W'(sbr_bit_period(div.prescaleSel, div.rateSel) - 1'b1)))
    else $error("bit time differs from 64 x prescale x rate");

  a_one_setting: assert property (
    ($changed(div.prescaleSel) || $changed(div.rateSel)) |-> $past(cfgCommit))
    else $error("rate setting changed outside a register write");

  a_tick_pulse: assert property (
    baudTick |=> !baudTick)
    else $error("bit enable longer than one cycle");

  a_restart_write: assert property (
    s_cfg_write |=> s_restart_pulse)
    else $error("rewrite did not restart the divider once");

  // Eight quiet cycles are only a floor; full spacing is judged above
  a_restart_quiet: assert property (
    div.restart |=> !baudTick [*8])
    else $error("bit enable too soon after restart");

  a_unmapped_err: assert property (
    (psel && !penable && !(paddr == BAUD_SEL_OFS || paddr == TICK_CNT_OFS))
      |=> pready && pslverr && (prdata == '0))
    else $error("unmapped address not refused");

  // The access answer stands for exactly one cycle
  a_answer_once: assert property (
    pready |=> !pready)
    else $error("access answer held longer than one cycle");

  // Outside the access cycle the answer lines rest at zero
  a_answer_quiet: assert property (
    !pready |-> (!pslverr && (prdata == '0)))
    else $error("error or read data shown outside the access cycle");

  // Software's tick count moves with every shared enable
  a_tick_count: assert property (
    baudTick |=> (state.tickCount == $past(state.tickCount) + 1'b1))
    else $error("tick count missed a shared bit enable");

endmodule

`default_nettype wire

/* File: inc/sbr_pkg.sv */
`default_nettype none

// ---------------------------------------------------------------
// Baud rate generator constants
// ---------------------------------------------------------------
package sbr_pkg;

  // APB geometry
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam int APB_STRB_W = 4;

  // Register byte offsets
  localparam logic [11:0] BAUD_SEL_OFS = 12'h000; // Rate selection
  localparam logic [11:0] TICK_CNT_OFS = 12'h004; // Tick counter, read only

  // Field layout of the rate selection register
  localparam int PRE_SEL_LSB  = 4;
  localparam int PRE_SEL_W    = 2;
  localparam int RATE_SEL_LSB = 0;
  localparam int RATE_SEL_W   = 3;

  // Reset values
  localparam logic [7:0]  BAUD_SEL_RST = 8'h00;
  localparam logic [31:0] TICK_CNT_RST = 32'h0000_0000;

  // Divider chain geometry
  localparam int FIXED_DIV   = 64; // Fixed factor inside the rate stage, ahead of 2**n
  localparam int PRE_CNT_W   = 4;  // Holds up to 13 - 1
  localparam int RATE_CNT_W  = 13; // Holds up to 64 * 128 - 1
  localparam int PERIOD_W    = 17; // Holds up to 64 * 13 * 128

  // Prescale factors per code
  localparam logic [3:0] PRE_DIV_0 = 4'h1;
  localparam logic [3:0] PRE_DIV_1 = 4'h3;
  localparam logic [3:0] PRE_DIV_2 = 4'h4;
  localparam logic [3:0] PRE_DIV_3 = 4'hd;

  // Prescale code to factor
  function automatic logic [3:0] sbr_prescale_factor(input logic [1:0] sel);
    unique case (sel)
      2'b00: return PRE_DIV_0;
      2'b01: return PRE_DIV_1;
      2'b10: return PRE_DIV_2;
      2'b11: return PRE_DIV_3;
    endcase
  endfunction

  // Rate code n to factor 2**n
  function automatic logic [7:0] sbr_rate_factor(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction

  // Clock cycles in one bit time for a given setting
  function automatic logic [PERIOD_W-1:0] sbr_bit_period(input logic [1:0] pre,
                                                        input logic [2:0] rate);
    return PERIOD_W'(FIXED_DIV) * PERIOD_W'(sbr_prescale_factor(pre))
           * PERIOD_W'(sbr_rate_factor(rate));
  endfunction

endpackage

`default_nettype wire

/* File: inc/sbr_div_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Link between control and the two divider stages
// ---------------------------------------------------------------
interface sbr_div_if;
  logic       restart;     // Clears both stages
  logic [1:0] prescaleSel; // Prescale code
  logic [2:0] rateSel;     // Rate exponent code
  logic       preTick;     // One pulse per prescale period
  logic       baudTick;    // One pulse per bit time

  modport ctrl (output restart, prescaleSel, rateSel, input preTick, baudTick);
  modport pre  (input restart, prescaleSel, output preTick);
  modport rate (input restart, rateSel, preTick, output baudTick);
endinterface

`default_nettype wire

/* File: hw/sbr_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Prescale stage: divides the generator clock by 1, 3, 4 or 13
// ---------------------------------------------------------------
module sbr_prescaler
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Divider link
  sbr_div_if.pre    div
);
  import sbr_pkg::*;

  typedef struct packed {
    logic [PRE_CNT_W-1:0] cnt;  // Cycles inside the current period
    logic                 tick; // Registered period pulse
  } sbr_pre_state_t;

  sbr_pre_state_t state;      // Current state
  sbr_pre_state_t next_state; // Next state
  logic [3:0]     factor;     // Decoded prescale factor

  // Count generator clock cycles, pulse once per factor
  always_comb
  begin
    next_state      = state;
    factor          = sbr_prescale_factor(div.prescaleSel);
    next_state.tick = 1'b0;
    if (div.restart)
    begin
      // Start a fresh period so the new factor applies at once
      next_state.cnt = '0;
    end
    else if (state.cnt == (factor - 4'h1))
    begin
      next_state.cnt  = '0;
      next_state.tick = 1'b1;
    end
    else
    begin
      next_state.cnt = state.cnt + 1'b1;
    end
  end

  // Register the state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign div.preTick = state.tick;

  // Factor one advances on every generator clock edge
  a_clock_source: assert property (@(posedge mclk) disable iff (!rst_n)
    (!div.restart && div.prescaleSel == 2'b00) |=> div.preTick)
    else $error("prescaler skipped a generator clock at factor one");

endmodule

`default_nettype wire

/* File: hw/sbr_rate_div.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Rate stage: fixed factor 64 times 2**n, counted in prescale ticks
// ---------------------------------------------------------------
module sbr_rate_div
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Divider link
  sbr_div_if.rate   div
);
  import sbr_pkg::*;

  typedef struct packed {
    logic [RATE_CNT_W-1:0] cnt;  // Prescale ticks in this bit
    logic                  tick; // Registered bit pulse
  } sbr_rate_state_t;

  sbr_rate_state_t         state;      // Current state
  sbr_rate_state_t         next_state; // Next state
  logic [RATE_CNT_W:0]     span;       // 64 * 2**n, one bit wider
  logic [RATE_CNT_W-1:0]   last;       // Terminal count

  // Count prescale ticks up to 64 * 2**n, then pulse
  always_comb
  begin
    next_state      = state;
    span            = (RATE_CNT_W+1)'(FIXED_DIV) << div.rateSel;
    last            = RATE_CNT_W'(span - 1'b1);
    next_state.tick = 1'b0;
    if (div.restart)
    begin
      next_state.cnt = '0;
    end
    else if (div.preTick)
    begin
      if (state.cnt == last)
      begin
        next_state.cnt  = '0;
        next_state.tick = 1'b1;
      end
      else
      begin
        next_state.cnt = state.cnt + 1'b1;
      end
    end
  end

  // Register the state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign div.baudTick = state.tick;

endmodule

`default_nettype wire

/* File: testbench/sbr_serial_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Receiver and transmitter side, stepping on the shared bit enable
// ---------------------------------------------------------------
module sbr_serial_model
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Shared bit enable from the generator
  input  wire logic        baudTick,
  // Observed timing, for the bench to judge
  output logic      [15:0] tickTotal,
  output logic      [16:0] lastGap
);
  logic [16:0] sinceTick; // Cycles since the last bit enable

  // Both directions step on the one enable, no rate of their own
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tickTotal <= 16'h0000;
      lastGap   <= 17'h00000;
      sinceTick <= 17'h00000;
    end
    else if (baudTick)
    begin
      tickTotal <= tickTotal + 16'h0001;
      lastGap   <= sinceTick + 17'h00001;
      sinceTick <= 17'h00000;
    end
    else
    begin
      sinceTick <= sinceTick + 17'h00001;
    end
  end
endmodule

`default_nettype wire

/* File: testbench/sbr_baud_gen_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Self-checking bench for the baud rate generator
// ---------------------------------------------------------------
module sbr_baud_gen_tb;
  import sbr_pkg::*;

  logic        mclk;      // Generator clock
  logic        rst_n;     // Chip reset
  logic        psel;      // APB request
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;    // APB answer
  logic        pready;
  logic        pslverr;
  logic        baudTick;  // Shared bit enable
  logic [15:0] tickTotal; // Far side view
  logic [16:0] lastGap;
  int          fail_count;
  int          cmp_count;
  int          cycles;    // Hang guard

  sbr_baud_gen #(.TICK_CNT_W(32)) uut
  (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .baudTick(baudTick)
  );

  sbr_serial_model farSide
  (
    .mclk(mclk), .rst_n(rst_n), .baudTick(baudTick),
    .tickTotal(tickTotal), .lastGap(lastGap)
  );

  // 125 MHz
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // All cases together take about 61k cycles, three bit times per rate case
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Single compare for every kind of result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound, never assumes it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      fail_count++;
  endtask

  // Cycles until the next enable, bounded
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (baudTick !== 1'b1 && n < 20000);
    if (n >= 20000)
      fail_count++;
  endtask

  // Two ticks; the pulse is one cycle wide and the far side sees the gap
  task automatic check_gap(input logic [31:0] exp);
    int n;
    wait_tick(n);
    wait_tick(n);
    @(posedge mclk);
    chk({31'h0, baudTick}, 32'h0);
    chk({15'h0, lastGap}, exp);
  endtask

  // Reset values of both registers and the default rate
  task automatic reset_case();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, BAUD_SEL_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0);
    chk(rd & 32'h7, 32'h0);
    apb(1'b0, TICK_CNT_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0);
    check_gap(32'd64);
  endtask

  // Program a setting, read it back, check restart and spacing
  task automatic rate_case(input logic [1:0] p, input logic [2:0] r);
    logic [31:0] rd;
    logic        er;
    logic [31:0] pdTab [4];
    int          n;
    logic [31:0] per;
    pdTab = '{32'd1, 32'd3, 32'd4, 32'd13};
    per   = 32'd64 * pdTab[p] * (32'h1 << r);
    apb(1'b1, BAUD_SEL_OFS, {26'h0, p, 1'b0, r}, 4'hf, rd, er);
    chk({31'h0, er}, 32'h0);
    wait_tick(n);
    chk({31'h0, (n >= 64) && (n <= per + 8)}, 32'h1);
    apb(1'b0, BAUD_SEL_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, {26'h0, p, 1'b0, r});
    check_gap(per);
  endtask

  // Unmapped read, read-only write, write with its lane masked
  task automatic error_case();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 12'h008, 32'h0, 4'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, TICK_CNT_OFS, 32'hffff_ffff, 4'hf, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, TICK_CNT_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, {16'h0, tickTotal});
    apb(1'b1, BAUD_SEL_OFS, 32'h0000_0037, 4'he, rd, er);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, BAUD_SEL_OFS, 32'h0, 4'h0, rd, er);
    chk(rd, 32'h0000_0012);
  endtask

  // Main sequence
  initial
  begin
    fail_count = 0;
    cmp_count  = 0;
    cycles     = 0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    pstrb      = 4'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    reset_case();
    for (int p = 0; p < 4; p++)
      rate_case(2'(p), 3'b000);
    for (int r = 1; r < 8; r++)
      rate_case(2'b00, 3'(r));
    rate_case(2'b11, 3'b001);
    rate_case(2'b01, 3'b010);
    error_case();
    end_of_test();
  end
endmodule

`default_nettype wire
